//--- rtl/port_status_defines.vh
// register map, field layout and reset values for the port status and mode registers
// Summary of operation
// RULE1: four per-port detect/class status registers
// RULE2: detection codes: unknown through negative DC source
// RULE3: class codes: unknown, 1-5, 0, limit
// RULE4: two-step classification forces class field zero
// RULE5: high-cap enable accepts loads up to 100uF
// RULE6: class fault blocks power when enabled
// RULE7: status registers clear on reset
// RULE8: power-good set after qualified startup only
// RULE9: power-good clears on exit or fault
// RULE10: power-on flag follows port switch state
// RULE11: flag transitions set change-event bits
// RULE12: power status: good high nibble, on low
// RULE13: straps latched at reset, later ignored
// RULE14: two mode bits per port, port1 lowest
// RULE15: mode resets to latched autonomous strap
// RULE16: port soft reset leaves mode untouched
// RULE17: mode codes shutdown, manual, semi, auto
// RULE18: reserved bits zero, read-only writes ignored
`ifndef PORT_STATUS_DEFINES_VH
`define PORT_STATUS_DEFINES_VH
`define ADDR_PORT1_STATUS 8'h0C
`define ADDR_PORT2_STATUS 8'h0D
`define ADDR_PORT3_STATUS 8'h0E
`define ADDR_PORT4_STATUS 8'h0F
`define ADDR_POWER_STATUS 8'h10
`define ADDR_STRAP_LATCH 8'h11
`define ADDR_MODE 8'h12
`define STATUS_RESET 8'h00
`define POWER_STATUS_RESET 8'h00
`define CODE_UNKNOWN 3'h0
`define POSITIVE_DC_SOURCE_CODE 3'h1
`define HIGH_CAP_CODE 3'h2
`define LOW_RESISTANCE_CODE 3'h3
`define VALID_SIGNATURE_CODE 3'h4
`define HIGH_RESISTANCE_CODE 3'h5
`define OPEN_PORT_CODE 3'h6
`define NEGATIVE_DC_SOURCE_CODE 3'h7
`define CLASS_LIMIT_CODE 3'h7
`define MODE_SHUTDOWN 2'h0
`define MODE_MANUAL 2'h1
`define MODE_SEMI_AUTO 2'h2
`define MODE_AUTO 2'h3
`define POWER_GOOD_FLAG_QUAL_NS 16000
// qualification span in 50 ns core cycles, rounded up from the time above
`define POWER_GOOD_FLAG_QUAL_CYCLES 10'h140
`define POWER_GOOD_FLAG_CNT_WIDTH 10
`endif

//--- rtl/port_power_tracker.v
// one port: power-good qualification, power-on flag and change events
`timescale 1ns/10ps
`include "port_status_defines.vh"
module port_power_tracker (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire switch_on,
  input wire pg_condition,
  input wire startup_end,
  input wire port_fault,
  output reg power_good_flag,
  output reg port_power_on_flag,
  output reg power_good_change_event,
  output reg power_on_change_event
);
  reg [`POWER_GOOD_FLAG_CNT_WIDTH-1:0] qual_count;
  wire qualified;
  reg next_pg;
  assign qualified = (qual_count >= `POWER_GOOD_FLAG_QUAL_CYCLES);
  always @*
  begin
    next_pg = power_good_flag;
    if (startup_end && qualified && switch_on)
      next_pg = 1'b1; // [RULE8]
    if (!pg_condition || port_fault || !switch_on)
      next_pg = 1'b0; // [RULE9]
  end
  always @(posedge clk)
  begin
    if (reset)
    begin
      qual_count <= {`POWER_GOOD_FLAG_CNT_WIDTH{1'b0}};
      power_good_flag <= 1'b0;
      port_power_on_flag <= 1'b0;
      power_good_change_event <= 1'b0;
      power_on_change_event <= 1'b0;
    end
    else if (ce)
    begin
      // qualification must be continuous: any dropout restarts it
      if (!pg_condition || port_fault)
        qual_count <= {`POWER_GOOD_FLAG_CNT_WIDTH{1'b0}};
      else if (!qualified)
        qual_count <= qual_count + 1'b1; // [RULE8]
      power_good_flag <= next_pg;
      port_power_on_flag <= switch_on; // [RULE10]
      power_good_change_event <= (next_pg != power_good_flag); // [RULE11]
      power_on_change_event <= (switch_on != port_power_on_flag); // [RULE11]
    end
    else
    begin
      power_good_change_event <= 1'b0;
      power_on_change_event <= 1'b0;
    end
  end
endmodule // port_power_tracker

//--- rtl/port_status_mode_registers.v
// port status, power status, strap latch and mode registers for four ports
`timescale 1ns/10ps
`include "port_status_defines.vh"
module port_status_mode_registers (
  input wire CORE_CLK,
  input wire RESET,
  input wire CLK_EN,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  input wire [3:0] DETECT_DONE,
  input wire [11:0] DETECT_CODE,
  input wire [3:0] CLASS_DONE,
  input wire [11:0] CLASS_CODE,
  input wire [3:0] TWO_STEP_CLASS_ENABLE,
  input wire HIGH_CAP_DETECT_ENABLE,
  input wire HIGH_CAP_OK,
  input wire CLASS_FAULT_POWER_BLOCK,
  input wire [3:0] POWER_REQUEST,
  input wire [3:0] PG_CONDITION,
  input wire [3:0] STARTUP_END,
  input wire [3:0] PORT_FAULT,
  input wire [3:0] ADDR_STRAP,
  input wire SPARE_PAIR_STRAP,
  input wire AUTONOMOUS_STRAP,
  output reg [3:0] PORT_SWITCH_ON,
  output reg [7:0] PORT_MODE,
  output reg [3:0] POWER_GOOD_CHANGE_EVENT,
  output reg [3:0] POWER_ON_CHANGE_EVENT
);
  reg [7:0] port_status [0:3];
  reg [5:0] strap_latch;
  reg [5:0] strap_sync1;
  reg [5:0] strap_sync2;
  reg [3:0] pg_sync1;
  reg [3:0] pg_sync2;
  reg [3:0] fault_sync1;
  reg [3:0] fault_sync2;
  reg strap_pending;
  wire [3:0] power_good_flag;
  wire [3:0] port_power_on_flag;
  wire [3:0] pg_evt;
  wire [3:0] pwr_evt;
  reg [7:0] next_rdata;

  function [2:0] detect_map;
    input [2:0] code;
    input high_cap_en;
    input high_cap_ok;
    begin
      // with the high-cap option a large but acceptable load counts as a pass
      if (high_cap_en && high_cap_ok && code == `HIGH_CAP_CODE)
        detect_map = `VALID_SIGNATURE_CODE; // [RULE5]
      else
        detect_map = code; // [RULE2]
    end
  endfunction

  // straps and analog-side levels come from outside the clock domain
  always @(posedge CORE_CLK)
  begin
    strap_sync1 <= {ADDR_STRAP, SPARE_PAIR_STRAP, AUTONOMOUS_STRAP};
    strap_sync2 <= strap_sync1;
    pg_sync1 <= PG_CONDITION;
    pg_sync2 <= pg_sync1;
    fault_sync1 <= PORT_FAULT;
    fault_sync2 <= fault_sync1;
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_port
      always @(posedge CORE_CLK)
      begin
        if (RESET)
          port_status[i] <= `STATUS_RESET; // [RULE7]
        else if (CLK_EN)
        begin
          if (DETECT_DONE[i])
            port_status[i][2:0] <= detect_map(DETECT_CODE[3*i+2:3*i], HIGH_CAP_DETECT_ENABLE, HIGH_CAP_OK);
          if (TWO_STEP_CLASS_ENABLE[i])
            port_status[i][6:4] <= `CODE_UNKNOWN; // [RULE4]
          else if (CLASS_DONE[i])
            port_status[i][6:4] <= CLASS_CODE[3*i+2:3*i]; // [RULE3]
          port_status[i][7] <= 1'b0; // [RULE18]
          port_status[i][3] <= 1'b0; // [RULE18]
        end
      end

      always @(posedge CORE_CLK)
      begin
        if (RESET)
          PORT_SWITCH_ON[i] <= 1'b0;
        else if (CLK_EN)
        begin
          if (CLASS_FAULT_POWER_BLOCK && port_status[i][6:4] == `CLASS_LIMIT_CODE)
            PORT_SWITCH_ON[i] <= 1'b0; // [RULE6]
          else
            PORT_SWITCH_ON[i] <= POWER_REQUEST[i] && (PORT_MODE[2*i+1:2*i] != `MODE_SHUTDOWN); // [RULE17]
        end
      end

      port_power_tracker u_tracker (
        .clk(CORE_CLK),
        .reset(RESET),
        .ce(CLK_EN),
        .switch_on(PORT_SWITCH_ON[i]),
        .pg_condition(pg_sync2[i]),
        .startup_end(STARTUP_END[i]),
        .port_fault(fault_sync2[i]),
        .power_good_flag(power_good_flag[i]),
        .port_power_on_flag(port_power_on_flag[i]),
        .power_good_change_event(pg_evt[i]),
        .power_on_change_event(pwr_evt[i])
      );
    end
  endgenerate

  // strap latch: mode reload uses the value held before this reset
  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      PORT_MODE <= {8{strap_latch[0]}}; // [RULE15]
      strap_pending <= 1'b1;
    end
    else if (CLK_EN)
    begin
      if (strap_pending)
      begin
        strap_latch <= strap_sync2; // [RULE13]
        strap_pending <= 1'b0;
      end
      if (REG_WR && REG_ADDR == `ADDR_MODE)
        PORT_MODE <= REG_WDATA; // [RULE14] [RULE16]
    end
  end

  always @*
  begin
    case (REG_ADDR)
      `ADDR_PORT1_STATUS: next_rdata = port_status[0]; // [RULE1]
      `ADDR_PORT2_STATUS: next_rdata = port_status[1];
      `ADDR_PORT3_STATUS: next_rdata = port_status[2];
      `ADDR_PORT4_STATUS: next_rdata = port_status[3];
      `ADDR_POWER_STATUS: next_rdata = {power_good_flag, port_power_on_flag}; // [RULE12]
      `ADDR_STRAP_LATCH: next_rdata = {2'h0, strap_latch}; // [RULE18]
      `ADDR_MODE: next_rdata = PORT_MODE;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      REG_RDATA <= 8'h00;
      POWER_GOOD_CHANGE_EVENT <= 4'h0;
      POWER_ON_CHANGE_EVENT <= 4'h0;
    end
    else if (CLK_EN)
    begin
      REG_RDATA <= next_rdata;
      POWER_GOOD_CHANGE_EVENT <= pg_evt; // [RULE11]
      POWER_ON_CHANGE_EVENT <= pwr_evt;
    end
  end
endmodule // port_status_mode_registers

//--- sim/port_status_checker.sv
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module port_status_checker (
  input wire CORE_CLK,
  input wire RESET,
  input wire CLK_EN,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire [3:0] POWER_REQUEST,
  input wire [3:0] PORT_SWITCH_ON,
  input wire [7:0] PORT_MODE,
  input wire [3:0] POWER_ON_CHANGE_EVENT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  wire mw = REG_WR && CLK_EN && REG_ADDR == 8'h12;
  mode_write_a: assert property (mw |=> PORT_MODE == $past(REG_WDATA))
    else $error("mode write");
  mode_hold_a: assert property (!mw |=> $stable(PORT_MODE))
    else $error("mode changed");
  status_zero_a: assert property ($past(REG_ADDR) inside {[8'h0C:8'h0F]} |-> (REG_RDATA & 8'h88) == 8'h00)
    else $error("status bits");
  strap_zero_a: assert property ($past(REG_ADDR) == 8'h11 |-> REG_RDATA[7:6] == 2'h0)
    else $error("strap bits");
  unmapped_zero_a: assert property (!($past(REG_ADDR) inside {[8'h0C:8'h12]}) |-> REG_RDATA == 8'h00)
    else $error("unmapped read");
  on_event_a: assert property ($changed(PORT_SWITCH_ON[0]) |-> ##[1:3] POWER_ON_CHANGE_EVENT[0])
    else $error("no change event");
  shutdown_off_a: assert property (PORT_MODE[1:0] == 2'h0 |=> !PORT_SWITCH_ON[0])
    else $error("switch on in shutdown");
  no_request_a: assert property (!POWER_REQUEST[0] [*2] |=> !PORT_SWITCH_ON[0])
    else $error("switch without request");
  cover property (mw);
  cover property ($rose(PORT_SWITCH_ON[0]));
  cover property (POWER_ON_CHANGE_EVENT[0]);
endmodule // port_status_checker
bind port_status_mode_registers port_status_checker u_chk (.*);

//--- sim/reg_host_model.sv
// host side: register reads and writes
`timescale 1ns/10ps
module reg_host_model (
  input wire CORE_CLK,
  input wire [7:0] REG_RDATA,
  output reg [7:0] REG_ADDR,
  output reg REG_WR,
  output reg [7:0] REG_WDATA
);
  initial {REG_ADDR, REG_WR, REG_WDATA} = 17'h0;
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge CORE_CLK) #1;
    {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
    @(posedge CORE_CLK) #1;
    // stale data flipped so a missing strobe check shows
    {REG_WDATA, REG_WR} = {~d, 1'b0};
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge CORE_CLK) #1;
    REG_ADDR = a;
    @(posedge CORE_CLK) #1;
    d = REG_RDATA;
  end
  endtask
endmodule // reg_host_model

//--- sim/port_status_mode_registers_tb_top.sv
// self-checking bench for the port status and mode registers
`timescale 1ns/10ps
module port_status_mode_registers_tb_top;
  reg CORE_CLK, RESET, CLK_EN, HIGH_CAP_DETECT_ENABLE, HIGH_CAP_OK, CLASS_FAULT_POWER_BLOCK;
  reg SPARE_PAIR_STRAP, AUTONOMOUS_STRAP;
  reg [3:0] DETECT_DONE, CLASS_DONE, TWO_STEP_CLASS_ENABLE, POWER_REQUEST, PG_CONDITION;
  reg [3:0] STARTUP_END, PORT_FAULT, ADDR_STRAP;
  reg [11:0] DETECT_CODE, CLASS_CODE;
  wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA, PORT_MODE;
  wire REG_WR;
  wire [3:0] PORT_SWITCH_ON, POWER_GOOD_CHANGE_EVENT, POWER_ON_CHANGE_EVENT;
  reg [7:0] d, e, ev_seen;
  reg ev_on;
  integer seed, mismatches, compares, i, p;
  port_status_mode_registers u_dut (.*);
  reg_host_model u_host (.*);
  // sticky record of every change pulse once the power test starts
  always @(posedge CORE_CLK)
    ev_seen <= ev_on ? (ev_seen | {POWER_GOOD_CHANGE_EVENT, POWER_ON_CHANGE_EVENT}) : 8'h00;
  initial
  begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  function [7:0] stat(input [2:0] det, input [2:0] cls, input hc);
    stat = {1'b0, cls, 1'b0, (hc && det == 3'h2) ? 3'h4 : det};
  endfunction
  task chk(input [7:0] id, input [7:0] x, input [7:0] g);
  begin
    compares = compares + 1;
    if (g !== x)
    begin
      mismatches = mismatches + 1;
      $display("ERROR item %h expected %h seen %h", id, x, g);
    end
  end
  endtask
  task rchk(input [7:0] a, input [7:0] x);
  begin
    u_host.rd(a, d);
    chk(a, x, d);
  end
  endtask
  task tick(input integer n);
  begin
    repeat (n) @(posedge CORE_CLK);
    #1;
  end
  endtask
  task do_reset;
  begin
    RESET = 1'b1;
    tick(10);
    RESET = 1'b0;
    tick(4);
  end
  endtask
  task end_sim;
  begin
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #3000000;
    mismatches = mismatches + 1;
    end_sim;
  end
  initial
  begin
    {seed, mismatches, compares} = {32'd54572, 64'd0};
    {HIGH_CAP_DETECT_ENABLE, HIGH_CAP_OK, CLASS_FAULT_POWER_BLOCK, DETECT_DONE, CLASS_DONE} = 11'h0;
    {TWO_STEP_CLASS_ENABLE, POWER_REQUEST, PG_CONDITION, STARTUP_END, PORT_FAULT} = 20'h0;
    {DETECT_CODE, CLASS_CODE, CLK_EN, SPARE_PAIR_STRAP, AUTONOMOUS_STRAP} = 27'h7;
    ev_on = 1'b0;
    ADDR_STRAP = $random(seed);
    e = {2'h0, ADDR_STRAP, 2'h3};
    do_reset;
    // later strap changes must not reach the latch
    {ADDR_STRAP, SPARE_PAIR_STRAP, AUTONOMOUS_STRAP} = {~ADDR_STRAP, 2'h0};
    rchk(8'h11, e);
    for (i = 12; i < 17; i = i + 1)
      rchk(i[7:0], 8'h00);
    do_reset;
    chk(8'hF0, 8'hFF, PORT_MODE);
    rchk(8'h11, {2'h0, ADDR_STRAP, 2'h0});
    $display("test reset and straps done");
    for (i = 0; i < 6; i = i + 1)
    begin
      e = (i == 0) ? 8'h1B : $random(seed);
      u_host.wr(8'h12, e);
      chk(8'hF0, e, PORT_MODE);
      u_host.wr(i[7:0] + 8'h0C, ~e);
      rchk(8'h12, e);
      rchk(i[7:0] + 8'h0C, (i == 5) ? {2'h0, ADDR_STRAP, 2'h0} : 8'h00);
    end
    for (p = 0; p < 4; p = p + 1)
      for (i = 0; i < 8; i = i + 1)
      begin
        DETECT_CODE = $random(seed);
        CLASS_CODE = $random(seed);
        DETECT_CODE[3*p +: 3] = i[2:0];
        CLASS_CODE[3*p +: 3] = ~i[2:0];
        TWO_STEP_CLASS_ENABLE = (i == 5) ? 4'hF : 4'h0;
        {HIGH_CAP_DETECT_ENABLE, HIGH_CAP_OK} = i[1:0] ^ p[1:0];
        {DETECT_DONE, CLASS_DONE} = {2{4'h1 << p}};
        tick(1);
        {DETECT_DONE, CLASS_DONE} = 8'h00;
        e = stat(i[2:0], (i == 5) ? 3'h0 : ~i[2:0], HIGH_CAP_DETECT_ENABLE && HIGH_CAP_OK);
        rchk(8'h0C + p[7:0], e);
      end
    $display("test result codes done");
    CLASS_CODE[11:9] = 3'h7;
    {CLASS_DONE, CLASS_FAULT_POWER_BLOCK} = 5'h11;
    tick(1);
    CLASS_DONE = 4'h0;
    u_host.wr(8'h12, 8'hFF);
    ev_on = 1'b1;
    {POWER_REQUEST, PG_CONDITION} = 8'hF3;
    tick(230);
    PG_CONDITION = 4'h7;
    tick(100);
    STARTUP_END = 4'hF;
    tick(1);
    STARTUP_END = 4'h0;
    tick(4);
    chk(8'hF1, 8'h07, {4'h0, PORT_SWITCH_ON});
    rchk(8'h10, 8'h37);
    {PORT_FAULT, PG_CONDITION} = 8'h11;
    tick(5);
    u_host.rd(8'h10, d);
    chk(8'h10, 8'h00, d & 8'hF0);
    POWER_REQUEST = 4'h0;
    tick(5);
    rchk(8'h10, 8'h00);
    rchk(8'h20, 8'h00);
    chk(8'hF2, 8'h37, ev_seen);
    $display("test power flags done");
    end_sim;
  end
endmodule // port_status_mode_registers_tb_top
